// ### logic/secure_wdt_pkg.sv
// Shared constants and the state type of the secure watchdog timer.
// Assumes a 32-bit APB slave with byte addresses counted from the block base.
package secure_wdt_pkg;

    // Register byte offsets from the block base.
    localparam logic [11:0] OFS_RELOAD_VALUE  = 12'h000;  // Reload value, read and write.
    localparam logic [11:0] OFS_CURRENT_COUNT = 12'h004;  // Current count, read only.
    localparam logic [11:0] OFS_CONTROL       = 12'h008;  // Watchdog control, read and write.
    localparam logic [11:0] OFS_REFRESH       = 12'h00C;  // Refresh register, write only.
    localparam logic [11:0] OFS_STATUS        = 12'h010;  // Block status, read only.

    // Field positions inside the control register.
    localparam int CTL_UP       = 8;   // Count direction, set for up.
    localparam int CTL_ENABLE   = 7;   // Counter run enable.
    localparam int CTL_PERIODIC = 6;   // Periodic reload mode.
    localparam int CTL_WATCHDOG = 5;   // Watchdog mode enable.
    localparam int CTL_SECURE   = 4;   // Secure clear enable.
    localparam int CTL_PRE_HI   = 3;   // Prescaler field, upper bit.
    localparam int CTL_PRE_LO   = 2;   // Prescaler field, lower bit.
    localparam int CTL_IRQ_EN   = 1;   // Expiry gives an interrupt, not a reset.
    localparam int CTL_PD_HALT  = 0;   // Halt in power down.
    localparam int CTL_STORED   = 9;   // Implemented control bits.

    // Field positions inside the status register.
    localparam int STA_IRQ      = 0;   // Pending timer interrupt.
    localparam int STA_LOCKED   = 1;   // Watchdog entered, writes locked.

    // Values after reset.
    localparam logic [15:0] RELOAD_RESET = 16'h03D7;   // Reload value after reset.
    localparam logic [15:0] COUNT_RESET  = 16'h03D7;   // Count after reset.
    localparam logic [8:0]  CTRL_RESET   = 9'h000;     // Control after reset.
    localparam logic [7:0]  LFSR_RESET   = 8'h00;      // Expected refresh after reset.

    // Constants of the counter and the sequence generator.
    localparam logic [15:0] COUNT_MAX    = 16'hFFFF;   // Up-count overflow point.
    localparam logic [7:0]  LFSR_TAPS    = 8'h63;      // Taps for x^6, x^5, x and 1.
    localparam logic [1:0]  PRE_DIV1     = 2'b00;      // Only defined prescaler code.

    // Complete state of the block, registered as one word.
    typedef struct packed {
        logic [8:0]  ctrl;      // Stored control bits.
        logic [15:0] reload;    // Reload value.
        logic [15:0] count;     // Current count.
        logic [7:0]  lfsr;      // Expected refresh value.
        logic        irqFlag;   // Pending timer interrupt.
        logic        wdtReset;  // System reset request pulse.
        logic        oscMeta;   // First synchroniser stage of the tick.
        logic        oscSync;   // Second synchroniser stage of the tick.
        logic        oscPrev;   // Delayed tick level for edge detection.
        logic [31:0] prdata;    // APB read data.
        logic        pready;    // APB ready.
        logic        pslverr;   // APB error.
    } wdt_state_t;

endpackage : secure_wdt_pkg

// ### logic/secure_watchdog_timer.sv
// Secure watchdog timer: 16-bit up/down timer with a watchdog mode and an
// LFSR-checked refresh, reached over APB.
// Assumes a 32.768 kHz oscillator square wave on oscClkIn, power-down and
// debug-halt levels from logic on clk_sys, and rst_b as the power-on reset.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Control bit 8 selects up, else down.
// - Control bit 7 runs the counter.
// - Bit 6 periodic reload, else free running.
// - Bit 5 enters watchdog operation.
// - Bit 4 enables secure clear, off.
// - Prescaler bits 3:2 only divide-by-one.
// - Bit 1: expiry gives IRQ, not reset.
// - Bit 0 halts counter in power down.
// - Secure refresh must equal expected LFSR.
// - LFSR polynomial x8+x6+x5+x+1.
// - Refresh write before watchdog captures seed.
// - Matching refresh reloads and steps LFSR.
// - Mismatching refresh resets at once.
// - Zero seed forces immediate reset when secure clear is on.
// - LFSR state has no read path.
// - Seed 0xAA accepts 0xAA, 0x37, 0x6E.
// - Reload on periodic or watchdog expiry and refresh write.
// - Watchdog decrements to zero then fires.
// - Watchdog locks load and control writes.
// - Debug halt stops the counter.
module secure_watchdog_timer (
    input  wire logic        clk_sys,          // System clock, 40 MHz.
    input  wire logic        rst_b,            // Synchronous power-on reset, active low.
    input  wire logic        psel,             // APB select.
    input  wire logic        penable,          // APB enable.
    input  wire logic        pwrite,           // APB write direction.
    input  wire logic [11:0] paddr,            // APB byte address.
    input  wire logic [31:0] pwdata,           // APB write data.
    output logic      [31:0] prdata,           // APB read data.
    output logic             pready,           // APB ready.
    output logic             pslverr,          // APB error for unmapped addresses.
    input  wire logic        oscClkIn,         // 32.768 kHz timer source.
    input  wire logic        periphPowerDown,  // Peripherals powered down.
    input  wire logic        debugHalt,        // Debugger holds the processor.
    output logic             timerIrq,         // Timer interrupt, level.
    output logic             wdtReset          // System reset request, one-cycle pulse; held high while the secure seed is zero.
);

    // Registered state and its next value.
    secure_wdt_pkg::wdt_state_t st_ff;     // Current state.
    secure_wdt_pkg::wdt_state_t nxt_st;    // Next state.

    // Next state of the refresh sequence, left-shift Galois form.
    function automatic logic [7:0] lfsrNext(input logic [7:0] cur);
        lfsrNext = {cur[6:0], 1'b0} ^ (cur[7] ? secure_wdt_pkg::LFSR_TAPS : 8'h00);
    endfunction : lfsrNext

    // APB phase and address decode.
    logic setupPhase;   // First cycle of a transfer.
    logic accessWr;     // Write completing at this edge.
    logic addrHit;      // Address is mapped.
    logic wrReload;     // Write to reload value.
    logic wrCtrl;       // Write to control.
    logic wrRefresh;    // Write to refresh register.
    logic [31:0] readMux; // Read data for the addressed register.

    // Decode is combinational; pready comes one cycle after setup, so every
    // transfer has exactly one access cycle.
    always_comb begin
        setupPhase = psel & ~penable;
        accessWr   = psel & penable & st_ff.pready & pwrite;
        addrHit    = (paddr == secure_wdt_pkg::OFS_RELOAD_VALUE)
                   | (paddr == secure_wdt_pkg::OFS_CURRENT_COUNT)
                   | (paddr == secure_wdt_pkg::OFS_CONTROL)
                   | (paddr == secure_wdt_pkg::OFS_REFRESH)
                   | (paddr == secure_wdt_pkg::OFS_STATUS);
        wrReload   = accessWr & (paddr == secure_wdt_pkg::OFS_RELOAD_VALUE);
        wrCtrl     = accessWr & (paddr == secure_wdt_pkg::OFS_CONTROL);
        wrRefresh  = accessWr & (paddr == secure_wdt_pkg::OFS_REFRESH);
        // The refresh register reads zero and never shows the LFSR.
        readMux    = 32'h0000_0000;
        case (paddr)
            secure_wdt_pkg::OFS_RELOAD_VALUE:  readMux = {16'h0000, st_ff.reload};
            secure_wdt_pkg::OFS_CURRENT_COUNT: readMux = {16'h0000, st_ff.count};
            // Bits 31:9 are not stored and read as zero.
            secure_wdt_pkg::OFS_CONTROL:       readMux = {23'h00_0000, st_ff.ctrl};
            secure_wdt_pkg::OFS_STATUS: begin
                readMux[secure_wdt_pkg::STA_IRQ]    = st_ff.irqFlag;
                readMux[secure_wdt_pkg::STA_LOCKED] = st_ff.ctrl[secure_wdt_pkg::CTL_WATCHDOG];
            end
            default:                           readMux = 32'h0000_0000;
        endcase
    end

    // Counter control terms.
    logic tickEdge;    // Rising edge of the synchronised oscillator.
    logic runCount;    // Counter advances this cycle.
    logic wdMode;      // Watchdog operation active.
    logic secureOn;    // Secure clear checking active.
    logic atEnd;       // Count stands at its terminal value.
    logic expire;      // Terminal count reached on a tick.
    logic refreshOk;   // Secure refresh matched the expected value.

    // The tick comes only from the synchronised pair; the metastable stage
    // is read by nothing but the second stage.
    always_comb begin
        tickEdge  = st_ff.oscSync & ~st_ff.oscPrev;
        // Reserved prescaler codes also divide by one.
        runCount  = tickEdge & st_ff.ctrl[secure_wdt_pkg::CTL_ENABLE]
                  & ~debugHalt
                  & ~(st_ff.ctrl[secure_wdt_pkg::CTL_PD_HALT] & periphPowerDown);
        wdMode    = st_ff.ctrl[secure_wdt_pkg::CTL_WATCHDOG];
        secureOn  = wdMode & st_ff.ctrl[secure_wdt_pkg::CTL_SECURE];
        if (wdMode || !st_ff.ctrl[secure_wdt_pkg::CTL_UP]) begin
            atEnd = (st_ff.count == 16'h0000);
        end else begin
            atEnd = (st_ff.count == secure_wdt_pkg::COUNT_MAX);
        end
        expire    = runCount & atEnd;
        refreshOk = (pwdata[7:0] == st_ff.lfsr) & (st_ff.lfsr != 8'h00);
    end

    // All state updates in one place; later assignments override earlier ones.
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.oscMeta  = oscClkIn;
        nxt_st.oscSync  = st_ff.oscMeta;
        nxt_st.oscPrev  = st_ff.oscSync;
        nxt_st.wdtReset = 1'b0;
        // APB answer, registered so the ports come straight from flops.
        nxt_st.pready   = setupPhase;
        nxt_st.pslverr  = setupPhase & ~addrHit;
        if (setupPhase) begin
            nxt_st.prdata = readMux;
        end
        // Once the watchdog is entered, reload and control are frozen until
        // power-on reset, so a runaway program cannot disarm it.
        if (wrReload && !wdMode) begin
            nxt_st.reload = pwdata[15:0];
        end
        if (wrCtrl && !wdMode) begin
            nxt_st.ctrl = pwdata[secure_wdt_pkg::CTL_STORED-1:0];
        end
        // Refresh write has priority over counting in the same cycle.
        if (wrRefresh) begin
            if (secureOn) begin
                if (refreshOk) begin
                    nxt_st.count = st_ff.reload;
                    nxt_st.lfsr  = lfsrNext(st_ff.lfsr);
                end else begin
                    nxt_st.wdtReset = 1'b1;
                end
            end else begin
                nxt_st.count   = st_ff.reload;
                nxt_st.irqFlag = 1'b0;
                if (!wdMode) begin
                    nxt_st.lfsr = pwdata[7:0];
                end
            end
        end else if (runCount) begin
            if (wdMode) begin
                if (atEnd) begin
                    nxt_st.count = st_ff.reload;
                    if (st_ff.ctrl[secure_wdt_pkg::CTL_IRQ_EN]) begin
                        nxt_st.irqFlag = 1'b1;
                    end else begin
                        nxt_st.wdtReset = 1'b1;
                    end
                end else begin
                    nxt_st.count = st_ff.count - 16'h0001;
                end
            end else if (st_ff.ctrl[secure_wdt_pkg::CTL_UP]) begin
                if (atEnd) begin
                    nxt_st.count = st_ff.ctrl[secure_wdt_pkg::CTL_PERIODIC] ?
                                   st_ff.reload : 16'h0000;
                end else begin
                    nxt_st.count = st_ff.count + 16'h0001;
                end
            end else begin
                if (atEnd) begin
                    nxt_st.count = st_ff.ctrl[secure_wdt_pkg::CTL_PERIODIC] ?
                                   st_ff.reload : secure_wdt_pkg::COUNT_MAX;
                end else begin
                    nxt_st.count = st_ff.count - 16'h0001;
                end
            end
        end
        // A normal-mode expiry in the same cycle as a refresh still sets the flag.
        if (expire && !wdMode) begin
            nxt_st.irqFlag = 1'b1;
        end
        // A zero expected value can never be matched, so it resets at once.
        if (secureOn && st_ff.lfsr == 8'h00) begin
            nxt_st.wdtReset = 1'b1;
        end
    end

    // Single state register with synchronous reset to constants.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_ff.ctrl     <= secure_wdt_pkg::CTRL_RESET;
            st_ff.reload   <= secure_wdt_pkg::RELOAD_RESET;
            st_ff.count    <= secure_wdt_pkg::COUNT_RESET;
            st_ff.lfsr     <= secure_wdt_pkg::LFSR_RESET;
            st_ff.irqFlag  <= 1'b0;
            st_ff.wdtReset <= 1'b0;
            st_ff.oscMeta  <= 1'b0;
            st_ff.oscSync  <= 1'b0;
            st_ff.oscPrev  <= 1'b0;
            st_ff.prdata   <= 32'h0000_0000;
            st_ff.pready   <= 1'b0;
            st_ff.pslverr  <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs are taken straight from the state register.
    assign prdata   = st_ff.prdata;
    assign pready   = st_ff.pready;
    assign pslverr  = st_ff.pslverr;
    assign timerIrq = st_ff.irqFlag;
    assign wdtReset = st_ff.wdtReset;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Accepted secure refresh steps the sequence exactly once.
    lfsr_step_a: assert property (wrRefresh && secureOn && refreshOk |=>
        st_ff.lfsr == lfsrNext($past(st_ff.lfsr)) && st_ff.count == $past(st_ff.reload))
        else $error("Secure refresh did not step the sequence.");

    // Wrong refresh value gives a reset pulse in the next cycle.
    bad_refresh_a: assert property (wrRefresh && secureOn && !refreshOk |=> wdtReset)
        else $error("Mismatched refresh did not reset.");

    // Zero expected value keeps reset asserted.
    zero_seed_a: assert property (secureOn && st_ff.lfsr == 8'h00 |=> wdtReset)
        else $error("Zero seed did not force reset.");

    // Locked watchdog ignores load and control writes.
    wd_lock_a: assert property (wdMode && (wrReload || wrCtrl) |=>
        $stable(st_ff.reload) && $stable(st_ff.ctrl))
        else $error("Locked register was written.");

    // Debug halt freezes the count unless a refresh reloads it.
    debug_halt_a: assert property (debugHalt && !wrRefresh |=> $stable(st_ff.count))
        else $error("Count moved during debug halt.");

    // Stopped timer holds its count.
    stopped_hold_a: assert property (!st_ff.ctrl[secure_wdt_pkg::CTL_ENABLE] && !wrRefresh
        |=> $stable(st_ff.count))
        else $error("Disabled timer changed count.");

    // Up count adds exactly one per tick.
    up_count_a: assert property (runCount && !wdMode && !wrRefresh && !atEnd
        && st_ff.ctrl[secure_wdt_pkg::CTL_UP] |=> st_ff.count == $past(st_ff.count) + 16'h0001)
        else $error("Up count step wrong.");

    // Refresh before watchdog entry captures the seed.
    seed_capture_a: assert property (wrRefresh && !wdMode |=>
        st_ff.lfsr == $past(pwdata[7:0]) && !timerIrq || $past(expire))
        else $error("Seed not captured.");

    // Watchdog expiry selects interrupt or reset, one cycle later.
    expiry_mode_a: assert property (expire && wdMode && !wrRefresh |=>
        ($past(st_ff.ctrl[secure_wdt_pkg::CTL_IRQ_EN]) ? timerIrq : wdtReset))
        else $error("Watchdog expiry gave the wrong event.");

    // Power-down halt holds the count when selected.
    pd_halt_a: assert property (st_ff.ctrl[secure_wdt_pkg::CTL_PD_HALT] && periphPowerDown
        && !wrRefresh |=> $stable(st_ff.count))
        else $error("Count moved in power down.");

    // Down count takes exactly one per tick.
    down_count_a: assert property (runCount && !wdMode && !wrRefresh && !atEnd
        && !st_ff.ctrl[secure_wdt_pkg::CTL_UP]
        |=> st_ff.count == $past(st_ff.count) - 16'h0001)
        else $error("Down count step wrong.");

    // Periodic terminal count reloads rather than wrapping.
    periodic_reload_a: assert property (runCount && !wdMode && !wrRefresh && atEnd
        && st_ff.ctrl[secure_wdt_pkg::CTL_PERIODIC] |=> st_ff.count == $past(st_ff.reload))
        else $error("Periodic reload missed.");

    // A plain refresh write reloads the count whatever else happens.
    refresh_reload_a: assert property (wrRefresh && !secureOn |=>
        st_ff.count == $past(st_ff.reload))
        else $error("Refresh did not reload.");

    // A plain refresh clears the flag unless an expiry sets it in that cycle.
    irq_clear_a: assert property (wrRefresh && !secureOn && !expire |=> !timerIrq)
        else $error("Refresh did not clear the interrupt.");

    // Watchdog expiry starts a new period from the reload value.
    wd_reload_a: assert property (expire && wdMode && !wrRefresh |=>
        st_ff.count == $past(st_ff.reload))
        else $error("Watchdog did not reload on expiry.");

    // Main scenarios reached.
    secure_ok_c:  cover property (wrRefresh && secureOn && refreshOk);
    wd_reset_c:   cover property (expire && wdMode && !st_ff.ctrl[secure_wdt_pkg::CTL_IRQ_EN]);
    up_wrap_c:    cover property (expire && !wdMode && st_ff.ctrl[secure_wdt_pkg::CTL_UP]);
    bad_refr_c:   cover property (wrRefresh && secureOn && !refreshOk);
    zero_seed_c:  cover property (secureOn && st_ff.lfsr == 8'h00);

endmodule : secure_watchdog_timer

`default_nettype wire

// ### tb/secure_watchdog_timer_tb_top.sv
// Self-checking bench for the secure watchdog timer, driven over APB.
// Assumes the design package is compiled first; the bench makes each tick itself.
`timescale 1ns/1ps
`default_nettype none

module secure_watchdog_timer_tb_top;

    // Short local names for the register offsets.
    localparam logic [11:0] A_RLD = secure_wdt_pkg::OFS_RELOAD_VALUE;   // Reload value.
    localparam logic [11:0] A_CNT = secure_wdt_pkg::OFS_CURRENT_COUNT;  // Current count.
    localparam logic [11:0] A_CTL = secure_wdt_pkg::OFS_CONTROL;        // Control.
    localparam logic [11:0] A_REF = secure_wdt_pkg::OFS_REFRESH;        // Refresh.
    localparam logic [11:0] A_STA = secure_wdt_pkg::OFS_STATUS;         // Status.

    logic        clk_sys = 1'b0;          // System clock.
    logic        rst_b = 1'b0;            // Reset, active low.
    logic        psel = 1'b0;             // APB select.
    logic        penable = 1'b0;          // APB enable.
    logic        pwrite = 1'b0;           // APB direction.
    logic [11:0] paddr = 12'h000;         // APB address.
    logic [31:0] pwdata = 32'h0000_0000;  // APB write data.
    logic [31:0] prdata;                  // APB read data.
    logic        pready;                  // APB ready.
    logic        pslverr;                 // APB error.
    logic        oscClkIn = 1'b0;         // Tick source, held low between ticks.
    logic        periphPowerDown = 1'b0;  // Power-down level.
    logic        debugHalt = 1'b0;        // Debug halt level.
    logic        timerIrq;                // Interrupt flag.
    logic        wdtReset;                // Reset request pulse.
    logic        slvErr;                  // Error seen with the last answer.
    logic [31:0] rdata;                   // Last read data.
    int          err_count = 0;           // Mismatches.
    int          checked = 0;             // Comparisons.
    int          pulses = 0;              // Reset request pulses seen.
    int          base;                    // Pulse count before a step.
    // Refresh values accepted after seed 0xAA.
    logic [7:0] seqVals [3] = '{8'hAA, 8'h37, 8'h6E};

    secure_watchdog_timer dut_u (
        .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .oscClkIn(oscClkIn),
        .periphPowerDown(periphPowerDown), .debugHalt(debugHalt),
        .timerIrq(timerIrq), .wdtReset(wdtReset)
    );

    // Clock at 40 MHz.
    always #12.5 clk_sys = ~clk_sys;

    // Pulses are counted as sampled, one for each cycle the request is high.
    always @(posedge clk_sys) begin
        if (wdtReset === 1'b1) begin
            pulses++;
        end
    end

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        checked++;
        if (seen !== want) begin
            err_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask : check

    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 32);
        rdata  = prdata;
        slvErr = pslverr;
        if (n >= 32) begin
            check(32'h0, 32'h1, "no ready");
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Reads a register and compares it.
    task automatic rdchk(input logic [11:0] a, input logic [31:0] want, input string what);
        apb(1'b0, a, 32'h0000_0000);
        check(rdata, want, what);
    endtask : rdchk

    // One tick: a full period of the slow source, long enough to land in the count.
    task automatic tick();
        @(posedge clk_sys);
        oscClkIn <= 1'b1;
        repeat (6) @(posedge clk_sys);
        oscClkIn <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask : tick

    // Power-on reset, the only way out of watchdog mode.
    task automatic do_reset();
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
    endtask : do_reset

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // Watchdog on the bench: the tests need well under 20000 cycles.
    initial begin
        #(25 * 20000);
        err_count++;
        summarize();
    end

    // Main sequence.
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        // Reset values, write-only refresh and an unmapped address.
        rdchk(A_RLD, 32'h0000_03D7, "reload reset");
        rdchk(A_CNT, 32'h0000_03D7, "count reset");
        rdchk(A_CTL, 32'h0000_0000, "control reset");
        rdchk(A_REF, 32'h0000_0000, "refresh reads zero");
        rdchk(12'h014, 32'h0000_0000, "unmapped read");
        check({31'h0, slvErr}, 32'h1, "unmapped error");
        $display("test reset values done");
        // Periodic down count, expiry and refresh clearing the flag.
        apb(1'b1, A_RLD, 32'h0000_0002);
        apb(1'b1, A_REF, 32'h0000_0055);
        rdchk(A_CNT, 32'h0000_0002, "refresh reloads");
        apb(1'b1, A_CTL, 32'h0000_00C0);
        tick();
        rdchk(A_CNT, 32'h0000_0001, "down count");
        tick();
        tick();
        rdchk(A_CNT, 32'h0000_0002, "periodic reload");
        check({31'h0, timerIrq}, 32'h1, "irq set");
        apb(1'b1, A_REF, 32'h0000_0000);
        rdchk(A_STA, 32'h0000_0000, "refresh clears irq");
        $display("test periodic down done");
        // Free-running up count wraps to zero.
        apb(1'b1, A_RLD, 32'h0000_FFFE);
        apb(1'b1, A_REF, 32'h0000_0001);
        apb(1'b1, A_CTL, 32'h0000_0180);
        tick();
        rdchk(A_CNT, 32'h0000_FFFF, "up count");
        tick();
        rdchk(A_CNT, 32'h0000_0000, "free-running wrap");
        // Disable, power-down halt and debug halt.
        apb(1'b1, A_CTL, 32'h0000_0100);
        tick();
        rdchk(A_CNT, 32'h0000_0000, "disabled holds");
        apb(1'b1, A_CTL, 32'h0000_0181);
        periphPowerDown <= 1'b1;
        tick();
        rdchk(A_CNT, 32'h0000_0000, "power-down halt");
        periphPowerDown <= 1'b0;
        debugHalt <= 1'b1;
        tick();
        rdchk(A_CNT, 32'h0000_0000, "debug halt");
        debugHalt <= 1'b0;
        tick();
        rdchk(A_CNT, 32'h0000_0001, "counts again");
        $display("test halts done");
        // Watchdog expiry with the interrupt option, and the write lock.
        do_reset();
        apb(1'b1, A_RLD, 32'h0000_0001);
        apb(1'b1, A_REF, 32'h0000_0011);
        apb(1'b1, A_CTL, 32'h0000_00A2);
        apb(1'b1, A_RLD, 32'h0000_0005);
        rdchk(A_RLD, 32'h0000_0001, "reload locked");
        rdchk(A_STA, 32'h0000_0002, "lock shown");
        base = pulses;
        tick();
        tick();
        rdchk(A_CNT, 32'h0000_0001, "watchdog reloads");
        check({31'h0, timerIrq}, 32'h1, "watchdog irq");
        check(pulses - base, 32'h0, "no reset with irq");
        // Watchdog expiry with reset.
        do_reset();
        apb(1'b1, A_RLD, 32'h0000_0001);
        apb(1'b1, A_REF, 32'h0000_0011);
        apb(1'b1, A_CTL, 32'h0000_00A0);
        base = pulses;
        tick();
        tick();
        check(pulses - base, 32'h1, "expiry reset");
        check({31'h0, timerIrq}, 32'h0, "no irq");
        $display("test watchdog expiry done");
        // Secure sequence from seed 0xAA, then a wrong value.
        do_reset();
        apb(1'b1, A_REF, 32'h0000_00AA);
        apb(1'b1, A_RLD, 32'h0000_0003);
        apb(1'b1, A_CTL, 32'h0000_00B0);
        apb(1'b1, A_CTL, 32'h0000_0000);
        rdchk(A_CTL, 32'h0000_00B0, "control locked");
        base = pulses;
        foreach (seqVals[i]) begin
            tick();
            apb(1'b1, A_REF, {24'h0, seqVals[i]});
            rdchk(A_CNT, 32'h0000_0003, "secure reload");
        end
        check(pulses - base, 32'h0, "sequence accepted");
        apb(1'b1, A_REF, 32'h0000_0066);
        rdchk(A_STA, 32'h0000_0002, "status after miss");
        check(pulses - base, 32'h1, "mismatch resets");
        // Zero expected value forces resets at once.
        do_reset();
        apb(1'b1, A_CTL, 32'h0000_00B0);
        base = pulses;
        repeat (6) @(posedge clk_sys);
        check({31'h0, (pulses - base) >= 4}, 32'h1, "zero seed resets");
        $display("test secure clear done");
        summarize();
    end

endmodule : secure_watchdog_timer_tb_top

`default_nettype wire
